// file: hw/usbm_ep_engine.sv
// Added by the designer: the register addresses and the APB register port.
`default_nettype none
module usbm_ep_engine #(
  parameter int NUM_EP = 3
) (
  // Clock and reset
  input  wire  logic                     sys_clk,
  input  wire  logic                     rst_n,
  // APB slave
  input  wire  logic                     psel,
  input  wire  logic                     penable,
  input  wire  logic                     pwrite,
  input  wire  logic [11:0]              paddr,
  input  wire  logic [31:0]              pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Serial_engine side
  input  wire  usbm_pkg::usbm_tok_t      tok,
  input  wire  usbm_pkg::usbm_dat_t      dat,
  input  wire  logic                     host_ack,
  input  wire  logic                     txn_abort,
  input  wire  logic [NUM_EP-1:0]        buf_corrupt,
  output usbm_pkg::usbm_hs_t             hs,
  // Endpoint interrupt requests and lock state
  output logic [NUM_EP-1:0]              ep_irq,
  output logic                           ep0_locked
);
  import usbm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode: Setup, In, Out responses
  function automatic logic [8:0] mode_resp(input logic [3:0] m);
    usbm_resp_t s;
    usbm_resp_t i;
    usbm_resp_t o;
    s = USBM_R_IGN;
    i = USBM_R_IGN;
    o = USBM_R_IGN;
    case (m)
      4'h0: begin s = USBM_R_IGN; i = USBM_R_IGN;   o = USBM_R_IGN;   end
      4'h1: begin s = USBM_R_ACC; i = USBM_R_NAK;   o = USBM_R_NAK;   end
      4'h2: begin s = USBM_R_ACC; i = USBM_R_STALL; o = USBM_R_CHECK; end
      4'h3: begin s = USBM_R_ACC; i = USBM_R_STALL; o = USBM_R_STALL; end
      4'h4: begin s = USBM_R_ACC; i = USBM_R_IGN;   o = USBM_R_IGN;   end
      4'h5: begin s = USBM_R_IGN; i = USBM_R_IGN;   o = USBM_R_ACC;   end
      4'h6: begin s = USBM_R_ACC; i = USBM_R_TX0;   o = USBM_R_STALL; end
      4'h7: begin s = USBM_R_IGN; i = USBM_R_TXCNT; o = USBM_R_IGN;   end
      4'h8: begin s = USBM_R_IGN; i = USBM_R_IGN;   o = USBM_R_NAK;   end
      4'h9: begin s = USBM_R_IGN; i = USBM_R_IGN;   o = USBM_R_ACK;   end
      4'ha: begin s = USBM_R_ACC; i = USBM_R_TX0;   o = USBM_R_NAK;   end
      4'hb: begin s = USBM_R_ACC; i = USBM_R_TX0;   o = USBM_R_ACK;   end
      4'hc: begin s = USBM_R_IGN; i = USBM_R_NAK;   o = USBM_R_IGN;   end
      4'hd: begin s = USBM_R_IGN; i = USBM_R_TXCNT; o = USBM_R_IGN;   end
      4'he: begin s = USBM_R_ACC; i = USBM_R_NAK;   o = USBM_R_CHECK; end
      4'hf: begin s = USBM_R_ACC; i = USBM_R_TXCNT; o = USBM_R_CHECK; end
      default: begin s = USBM_R_IGN; i = USBM_R_IGN; o = USBM_R_IGN; end
    endcase
    return {s, i, o};
  endfunction : mode_resp

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [3:0] mode_q  [NUM_EP];
  logic [2:0] stat_q  [NUM_EP];
  logic [3:0] cnt_q   [NUM_EP];
  logic       tog_q   [NUM_EP];
  logic       lock_q;

  // APB decode
  wire logic [2:0] reg_idx    = paddr[4:2];
  wire logic [1:0] reg_ep     = reg_idx[2:1];
  wire logic       reg_is_cnt = reg_idx[0];
  wire logic       mapped     = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00)
                                && (32'(reg_ep) < 32'(NUM_EP));
  wire logic       acc_end    = psel && penable && pready;
  wire logic       wr_acc     = acc_end && pwrite && mapped;
  wire logic       rd_acc     = acc_end && !pwrite && mapped;
  // release on read of endpoint 0 registers
  wire logic       ep0_read   = rd_acc && (reg_ep == 2'd0);

  //////////////////////////////////////////////////////////////////////////////
  // Transaction state machine
  typedef enum logic [1:0] {
    USBM_ST_IDLE,
    USBM_ST_DATA,
    USBM_ST_HACK
  } usbm_fsm_t;

  usbm_fsm_t  st_q;
  usbm_fsm_t  st_d;
  usbm_pid_t  pid_q;
  logic [1:0] ep_q;
  usbm_resp_t resp_q;
  usbm_hs_t   hs_q;
  usbm_hs_t   hs_d;

  wire logic       tok_ep_ok = tok.valid && (32'(tok.ep) < 32'(NUM_EP));
  wire logic [3:0] tok_mode  = tok_ep_ok ? mode_q[tok.ep] : USBM_M_DISABLE;
  wire logic [8:0] tok_rsp   = mode_resp(tok_mode);
  wire usbm_resp_t rsp_setup = usbm_resp_t'(tok_rsp[8:6]);
  wire usbm_resp_t rsp_in    = usbm_resp_t'(tok_rsp[5:3]);
  wire usbm_resp_t rsp_out   = usbm_resp_t'(tok_rsp[2:0]);
  wire usbm_resp_t tok_resp  = (tok.pid == USBM_PID_SETUP) ? rsp_setup :
                               (tok.pid == USBM_PID_IN)    ? rsp_in    :
                               (tok.pid == USBM_PID_OUT)   ? rsp_out   : USBM_R_IGN;
  wire logic       tok_take  = tok_ep_ok && (tok_resp != USBM_R_IGN);

  wire logic       dat_valid = dat.done && dat.ok && (dat.len <= USBM_MAX_LEN);
  wire logic       chk_pass  = (dat.len == USBM_ZERO_LEN) && dat.toggle_bit;

  // Completion events, one-cycle
  logic       fin;
  logic       fin_ack;
  // Interrupt-worthy completion; NAK and STALL ends only touch status
  logic       fin_irq;
  logic       mode_we;
  logic [3:0] mode_new;

  always_comb begin
    st_d     = st_q;
    hs_d     = '0;
    fin      = 1'b0;
    fin_ack  = 1'b0;
    fin_irq  = 1'b0;
    mode_we  = 1'b0;
    mode_new = mode_q[ep_q];
    case (st_q)
      USBM_ST_IDLE: begin
        if (tok_take) begin
          case (tok_resp)
            USBM_R_NAK, USBM_R_STALL: begin
              if (tok.pid == USBM_PID_IN) begin
                hs_d.valid = 1'b1;
                hs_d.kind  = (tok_resp == USBM_R_NAK) ? USBM_HS_NAK : USBM_HS_STALL;
                // In status set as the refusal ends the transaction
                fin        = 1'b1;
              end else begin
                st_d = USBM_ST_DATA;
              end
            end
            USBM_R_TX0, USBM_R_TXCNT: begin
              hs_d.valid      = 1'b1;
              hs_d.kind       = USBM_HS_DATA;
              hs_d.count      = (tok_resp == USBM_R_TXCNT) ? cnt_q[tok.ep] : 4'h0;
              hs_d.toggle_bit = tog_q[tok.ep];
              st_d            = (tok_mode == USBM_M_ACK_IN || tok_mode == USBM_M_ACKI_SO)
                                ? USBM_ST_HACK : USBM_ST_IDLE;
              // Zero length and isochronous replies finish without host ACK tracking
              fin             = (st_d == USBM_ST_IDLE);
              fin_irq         = fin;
            end
            default: st_d = USBM_ST_DATA;
          endcase
        end
      end
      USBM_ST_DATA: begin
        if (txn_abort || tok.valid) begin
          st_d = USBM_ST_IDLE;
        end else if (dat.done && !dat_valid) begin
          st_d = USBM_ST_IDLE;
        end else if (dat_valid) begin
          st_d       = USBM_ST_IDLE;
          fin        = 1'b1;
          hs_d.valid = 1'b1;
          case (resp_q)
            USBM_R_ACC: begin
              fin_irq = 1'b1;
              if (pid_q == USBM_PID_SETUP) begin
                hs_d.kind = USBM_HS_ACK;
                fin_ack   = 1'b1;
                mode_we   = 1'b1;
                mode_new  = USBM_M_NAK_IO;
              end else begin
                hs_d.valid = 1'b0;
              end
            end
            USBM_R_NAK:   hs_d.kind = USBM_HS_NAK;
            USBM_R_STALL: hs_d.kind = USBM_HS_STALL;
            USBM_R_CHECK: begin
              hs_d.kind = chk_pass ? USBM_HS_ACK : USBM_HS_STALL;
              fin_ack   = chk_pass;
              fin_irq   = chk_pass;
            end
            USBM_R_ACK: begin
              hs_d.kind = USBM_HS_ACK;
              fin_ack   = 1'b1;
              fin_irq   = 1'b1;
              mode_we   = 1'b1;
              mode_new  = (mode_q[ep_q] == USBM_M_ACK_OUT) ? USBM_M_NAK_OUT : USBM_M_NAKO_SI;
            end
            default: hs_d.valid = 1'b0;
          endcase
        end
      end
      USBM_ST_HACK: begin
        if (txn_abort || tok.valid) begin
          st_d = USBM_ST_IDLE;
        end else if (host_ack) begin
          st_d     = USBM_ST_IDLE;
          fin      = 1'b1;
          fin_ack  = 1'b1;
          fin_irq  = 1'b1;
          mode_we  = 1'b1;
          mode_new = (mode_q[ep_q] == USBM_M_ACK_IN) ? USBM_M_NAK_IN : USBM_M_NAKI_SO;
        end
      end
      default: st_d = USBM_ST_IDLE;
    endcase
  end

  // Endpoint and token of the event seen this cycle
  wire logic [1:0] ev_ep   = (st_q == USBM_ST_IDLE) ? tok.ep : ep_q;
  wire usbm_pid_t  ev_pid  = (st_q == USBM_ST_IDLE) ? tok.pid : pid_q;
  // setup status at data phase start
  wire logic       setup_seen = (st_q == USBM_ST_DATA) && dat.start && (pid_q == USBM_PID_SETUP);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= USBM_ST_IDLE;
      pid_q  <= USBM_PID_NONE;
      ep_q   <= 2'h0;
      resp_q <= USBM_R_IGN;
      hs_q   <= '0;
    end else begin
      st_q <= st_d;
      hs_q <= hs_d;
      if (st_q == USBM_ST_IDLE && tok_take) begin
        pid_q  <= tok.pid;
        ep_q   <= tok.ep;
        resp_q <= tok_resp;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-endpoint registers and interrupts
  logic [NUM_EP-1:0] irq_q;

  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++) begin : g_ep
      wire logic this_ev  = (32'(ev_ep) == e);
      wire logic locked   = (e == 0) && lock_q;
      wire logic cpu_sel  = wr_acc && (32'(reg_ep) == e) && !locked;
      // in and out status at transaction end
      wire logic st_in    = fin && this_ev && (ev_pid == USBM_PID_IN);
      wire logic st_out   = fin && this_ev && (ev_pid == USBM_PID_OUT);
      wire logic st_setup = setup_seen && this_ev;
      wire logic [2:0] st_set = {st_out, st_in, st_setup};

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_q[e] <= USBM_MODE_RST;
          stat_q[e] <= 3'h0;
          cnt_q[e]  <= USBM_CNT_RST;
          tog_q[e]  <= 1'b0;
          irq_q[e]  <= 1'b0;
        end else begin
          // Engine mode change wins over a CPU write in the same cycle
          if (mode_we && this_ev) begin
            mode_q[e] <= mode_new;
          end else if (cpu_sel && !reg_is_cnt) begin
            mode_q[e] <= pwdata[USBM_MODE_LSB +: 4];
          end
          // Hardware set wins over software clear
          if (cpu_sel && !reg_is_cnt) begin
            stat_q[e] <= pwdata[USBM_STAT_LSB +: 3] | st_set;
          end else begin
            stat_q[e] <= stat_q[e] | st_set;
          end
          if (cpu_sel && reg_is_cnt) begin
            cnt_q[e] <= pwdata[USBM_CNT_LSB +: 4];
            tog_q[e] <= pwdata[USBM_TOG_BIT];
          end
          irq_q[e] <= (fin_irq && this_ev) || buf_corrupt[e];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Endpoint 0 write interlock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    // lock after ACK on endpoint 0
    end else if (fin && fin_ack && (ev_ep == 2'd0)) begin
      lock_q <= 1'b1;
    end else if (ep0_read) begin
      lock_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, read data registered
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire logic [31:0] rd_mode = {24'h0, (reg_ep == 2'd0) && lock_q, 
                               mapped ? stat_q[reg_ep] : 3'h0,
                               mapped ? mode_q[reg_ep] : 4'h0};
  wire logic [31:0] rd_cnt  = {24'h0, mapped && tog_q[reg_ep], 3'h0,
                               mapped ? cnt_q[reg_ep] : 4'h0};
  wire logic [31:0] rd_word = !mapped ? 32'h0000_0000 : (reg_is_cnt ? rd_cnt : rd_mode);
  wire logic        req     = psel && penable && !pready_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= req;
      pslverr_q <= req && !mapped;
      if (req && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign prdata     = prdata_q;
  assign hs         = hs_q;
  assign ep_irq     = irq_q;
  assign ep0_locked = lock_q;

endmodule : usbm_ep_engine
`default_nettype wire

// file: hw/usbm_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
package usbm_pkg;

  // Register map, one aligned word per register, eight bytes per endpoint
  localparam logic [11:0] USBM_MODE_OFS   = 12'h000;
  localparam logic [11:0] USBM_COUNT_OFS  = 12'h004;
  localparam logic [11:0] USBM_EP_STRIDE  = 12'h008;

  // Mode register fields
  localparam int USBM_MODE_LSB  = 0;
  localparam int USBM_STAT_LSB  = 4;
  localparam int USBM_LOCK_BIT  = 7;
  // Status bit order inside the status field
  localparam int USBM_ST_SETUP  = 0;
  localparam int USBM_ST_IN     = 1;
  localparam int USBM_ST_OUT    = 2;
  // Count register fields
  localparam int USBM_CNT_LSB   = 0;
  localparam int USBM_TOG_BIT   = 7;

  // Reset values
  localparam logic [3:0] USBM_MODE_RST = 4'h0;
  localparam logic [3:0] USBM_CNT_RST  = 4'h0;

  // Modes the engine names; it writes only the NAK ones itself
  localparam logic [3:0] USBM_M_DISABLE  = 4'h0;
  localparam logic [3:0] USBM_M_NAK_IO   = 4'h1;
  localparam logic [3:0] USBM_M_NAK_OUT  = 4'h8;
  localparam logic [3:0] USBM_M_ACK_OUT  = 4'h9;
  localparam logic [3:0] USBM_M_NAKO_SI  = 4'ha;
  localparam logic [3:0] USBM_M_ACKO_SI  = 4'hb;
  localparam logic [3:0] USBM_M_NAK_IN   = 4'hc;
  localparam logic [3:0] USBM_M_ACK_IN   = 4'hd;
  localparam logic [3:0] USBM_M_NAKI_SO  = 4'he;
  localparam logic [3:0] USBM_M_ACKI_SO  = 4'hf;

  // Packet limits, byte counts include the two CRC bytes
  localparam logic [4:0] USBM_MAX_LEN    = 5'h0a;
  localparam logic [4:0] USBM_ZERO_LEN   = 5'h02;

  // Token identifiers from the serial_engine
  typedef enum logic [1:0] {
    USBM_PID_NONE,
    USBM_PID_SETUP,
    USBM_PID_IN,
    USBM_PID_OUT
  } usbm_pid_t;

  // Per-token response of a mode
  typedef enum logic [2:0] {
    USBM_R_IGN,
    USBM_R_ACC,
    USBM_R_NAK,
    USBM_R_STALL,
    USBM_R_TX0,
    USBM_R_TXCNT,
    USBM_R_CHECK,
    USBM_R_ACK
  } usbm_resp_t;

  // Handshake or data packet the serial_engine must send
  typedef enum logic [1:0] {
    USBM_HS_ACK,
    USBM_HS_NAK,
    USBM_HS_STALL,
    USBM_HS_DATA
  } usbm_hs_kind_t;

  // Token decoded by the serial_engine, valid for one cycle
  typedef struct packed {
    logic      valid;
    usbm_pid_t pid;
    logic [1:0] ep;
  } usbm_tok_t;

  // Data packet from the host: start and done are one-cycle pulses
  typedef struct packed {
    logic       start;
    logic       done;
    logic [4:0] len;
    logic       toggle_bit;
    logic       ok;
  } usbm_dat_t;

  // Answer to the serial_engine, valid for one cycle
  typedef struct packed {
    logic          valid;
    usbm_hs_kind_t kind;
    logic [3:0]    count;
    logic          toggle_bit;
  } usbm_hs_t;

endpackage : usbm_pkg
`default_nettype wire

// file: verification/usbm_ep_engine_sva.sv
`default_nettype none
module usbm_ep_engine_sva #(
  parameter int NUM_EP = 3
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rst_n,
  // APB side
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic                pready,
  // Serial_engine side
  input wire usbm_pkg::usbm_tok_t tok,
  input wire usbm_pkg::usbm_dat_t dat,
  input wire logic                host_ack,
  input wire logic [NUM_EP-1:0]   buf_corrupt,
  input wire usbm_pkg::usbm_hs_t  hs,
  input wire logic [NUM_EP-1:0]   ep_irq,
  input wire logic                ep0_locked
);
  import usbm_pkg::*;
  // Lock may drop on the read edge or one later, so both are accepted
  logic rd0;
  assign rd0 = psel && penable && pready && !pwrite && (paddr == USBM_MODE_OFS || paddr == USBM_COUNT_OFS);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  chk_hs_cause: assert property (
    hs.valid |-> $past(tok.valid || dat.done)) else $error("answer without token or packet");
  chk_bad_packet: assert property (
    dat.done && (!dat.ok || dat.len > USBM_MAX_LEN) && buf_corrupt == '0 |=> !hs.valid && ep_irq == '0)
    else $error("bad packet answered");
  chk_ack_cause: assert property (
    hs.valid && hs.kind == USBM_HS_ACK |-> $past(dat.done && dat.ok && dat.len <= USBM_MAX_LEN))
    else $error("ACK without a valid packet");
  chk_data_in: assert property (
    hs.valid && hs.kind == USBM_HS_DATA |-> $past(tok.valid && tok.pid == USBM_PID_IN))
    else $error("data sent without an In token");
  chk_irq_cause: assert property (
    |ep_irq |-> $past(tok.valid || dat.done || host_ack || |buf_corrupt)) else $error("interrupt without cause");
  chk_irq_split: assert property (
    !$past(|buf_corrupt) |-> $onehot0(ep_irq)) else $error("several endpoint interrupts at once");
  chk_lock_set: assert property (
    $rose(ep0_locked) |-> ep_irq[0]) else $error("lock set without completed transaction");
  chk_lock_free: assert property (
    $fell(ep0_locked) |-> $past(rd0) || $past(rd0, 2)) else $error("lock released without a read");
  chk_far_ep: assert property (
    tok.valid && tok.ep == 2'h3 |=> !hs.valid) else $error("answer to a missing endpoint");
endmodule : usbm_ep_engine_sva
bind usbm_ep_engine usbm_ep_engine_sva #(.NUM_EP(NUM_EP)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .tok(tok), .dat(dat), .host_ack(host_ack), .buf_corrupt(buf_corrupt), .hs(hs),
  .ep_irq(ep_irq), .ep0_locked(ep0_locked));
`default_nettype wire

// file: verification/usbm_host_model.sv
`default_nettype none
module usbm_host_model (
  // Clock
  input  wire logic               sys_clk,
  // Toward the endpoint logic
  output var usbm_pkg::usbm_tok_t tok,
  output var usbm_pkg::usbm_dat_t dat,
  output logic                    host_ack,
  output logic                    txn_abort
);
  import usbm_pkg::*;
  initial begin
    tok = '0;
    dat = '0;
    host_ack = 1'b0;
    txn_abort = 1'b0;
  end
  task automatic token(input usbm_pid_t pid, input logic [1:0] ep);
    @(posedge sys_clk);
    tok <= '{valid: 1'b1, pid: pid, ep: ep};
    @(posedge sys_clk);
    tok.valid <= 1'b0;
  endtask : token
  task automatic data(input logic [4:0] len, input logic tog, input logic ok);
    @(posedge sys_clk);
    dat.start <= 1'b1;
    @(posedge sys_clk);
    dat.start <= 1'b0;
    @(posedge sys_clk);
    dat <= '{start: 1'b0, done: 1'b1, len: len, toggle_bit: tog, ok: ok};
    // Stale fields are scrambled so nothing can lean on them after the packet
    @(posedge sys_clk);
    dat <= '{start: 1'b0, done: 1'b0, len: ~len, toggle_bit: ~tog, ok: ~ok};
  endtask : data
  task automatic acknowledge();
    @(posedge sys_clk);
    host_ack <= 1'b1;
    @(posedge sys_clk);
    host_ack <= 1'b0;
  endtask : acknowledge
  task automatic abort();
    @(posedge sys_clk);
    txn_abort <= 1'b1;
    @(posedge sys_clk);
    txn_abort <= 1'b0;
  endtask : abort
endmodule : usbm_host_model
`default_nettype wire

// file: verification/usbm_ep_engine_bench.sv
`default_nettype none
module usbm_ep_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import usbm_pkg::*;
  typedef struct packed {
    logic [3:0] m;
    usbm_pid_t  p;
    logic [2:0] e;
    logic [3:0] nm;
  } usbm_row_t;
  localparam usbm_pid_t PSU = USBM_PID_SETUP;
  localparam usbm_pid_t PIN = USBM_PID_IN;
  localparam usbm_pid_t POU = USBM_PID_OUT;
  // Expected answer: 0 ACK, 1 NAK, 2 STALL, 3 data, 4 silence
  usbm_row_t   rows[$] = '{
    '{4'h0, PSU, 3'h4, 4'h0}, '{4'h0, PIN, 3'h4, 4'h0}, '{4'h0, POU, 3'h4, 4'h0}, '{4'h1, PSU, 3'h0, 4'h1},
    '{4'h1, PIN, 3'h1, 4'h1}, '{4'h1, POU, 3'h1, 4'h1}, '{4'h2, PSU, 3'h0, 4'h1}, '{4'h2, PIN, 3'h2, 4'h2},
    '{4'h2, POU, 3'h2, 4'h2}, '{4'h3, PSU, 3'h0, 4'h1}, '{4'h3, PIN, 3'h2, 4'h3}, '{4'h3, POU, 3'h2, 4'h3},
    '{4'h4, PSU, 3'h0, 4'h1}, '{4'h4, PIN, 3'h4, 4'h4}, '{4'h4, POU, 3'h4, 4'h4}, '{4'h5, PSU, 3'h4, 4'h5},
    '{4'h5, PIN, 3'h4, 4'h5}, '{4'h6, PSU, 3'h0, 4'h1}, '{4'h6, PIN, 3'h3, 4'h6}, '{4'h6, POU, 3'h2, 4'h6},
    '{4'h7, PSU, 3'h4, 4'h7}, '{4'h7, PIN, 3'h3, 4'h7}, '{4'h7, POU, 3'h4, 4'h7}, '{4'h8, PSU, 3'h4, 4'h8},
    '{4'h8, PIN, 3'h4, 4'h8}, '{4'h8, POU, 3'h1, 4'h8}, '{4'h9, PSU, 3'h4, 4'h9}, '{4'h9, PIN, 3'h4, 4'h9},
    '{4'h9, POU, 3'h0, 4'h8}, '{4'ha, PSU, 3'h0, 4'h1}, '{4'ha, PIN, 3'h3, 4'ha}, '{4'ha, POU, 3'h1, 4'ha},
    '{4'hb, PSU, 3'h0, 4'h1}, '{4'hb, PIN, 3'h3, 4'hb}, '{4'hb, POU, 3'h0, 4'ha}, '{4'hc, PSU, 3'h4, 4'hc},
    '{4'hc, PIN, 3'h1, 4'hc}, '{4'hc, POU, 3'h4, 4'hc}, '{4'hd, PSU, 3'h4, 4'hd}, '{4'hd, PIN, 3'h3, 4'hc},
    '{4'hd, POU, 3'h4, 4'hd}, '{4'he, PSU, 3'h0, 4'h1}, '{4'he, PIN, 3'h1, 4'he}, '{4'he, POU, 3'h2, 4'he},
    '{4'hf, PSU, 3'h0, 4'h1}, '{4'hf, PIN, 3'h3, 4'he}, '{4'hf, POU, 3'h2, 4'hf}};
  logic        sys_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [2:0]  buf_corrupt = 3'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, host_ack, txn_abort, ep0_locked, er;
  usbm_tok_t   tok;
  usbm_dat_t   dat;
  usbm_hs_t    hs;
  logic [2:0]  ep_irq, irqs, seen_e;
  logic [3:0]  seen_cnt;
  int          miscompares = 0;
  int          n_tests     = 0;
  always #20 sys_clk = ~sys_clk;
  usbm_ep_engine #(.NUM_EP(3)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tok(tok), .dat(dat),
    .host_ack(host_ack), .txn_abort(txn_abort), .buf_corrupt(buf_corrupt), .hs(hs), .ep_irq(ep_irq),
    .ep0_locked(ep0_locked));
  usbm_host_model host (.sys_clk(sys_clk), .tok(tok), .dat(dat), .host_ack(host_ack), .txn_abort(txn_abort));
  // Answers and interrupts stand one cycle, so they are caught here
  always @(posedge sys_clk) begin
    irqs <= irqs | ep_irq;
    if (hs.valid === 1'b1) begin
      seen_e <= {1'b0, hs.kind};
      seen_cnt <= hs.count;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1, "bus answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [3:0] m, input usbm_pid_t p, input logic [4:0] len, input logic tog,
                     input logic ok, input logic [2:0] e, input logic [3:0] nm);
    logic [2:0] st;
    st = (e == 3'h4) ? 3'h0 : (p == PSU) ? 3'h1 : (p == PIN) ? 3'h2 : 3'h4;
    apb(1'b1, 12'h008, {28'h0, m});
    @(negedge sys_clk);
    irqs = 3'h0;
    seen_e = 3'h4;
    host.token(p, 2'h1);
    if (p != PIN)
      host.data(len, tog, ok);
    repeat (3) @(posedge sys_clk);
    // A host acknowledges every data packet except isochronous ones
    if (seen_e == 3'h3 && m != 4'h7)
      host.acknowledge();
    repeat (3) @(posedge sys_clk);
    check({29'h0, seen_e}, {29'h0, e}, "answer");
    check({29'h0, irqs}, (e == 3'h0 || e == 3'h3) ? 32'h2 : 32'h0, "interrupt");
    if (e == 3'h3)
      check({28'h0, seen_cnt}, (m == 4'h6 || m == 4'ha || m == 4'hb) ? 32'h0 : 32'h5, "count");
    apb(1'b0, 12'h008, 32'h0);
    check(rd, {25'h0, st, nm}, "mode");
  endtask : run
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b1, 12'h00c, 32'h5);
    apb(1'b1, 12'h004, 32'h5);
    foreach (rows[i])
      run(rows[i].m, rows[i].p, (rows[i].p == PSU) ? 5'h0a : 5'h04, 1'b0, 1'b1, rows[i].e, rows[i].nm);
    $display("test mode table done");
    run(4'h2, POU, 5'h02, 1'b1, 1'b1, 3'h0, 4'h2);
    run(4'h2, POU, 5'h02, 1'b0, 1'b1, 3'h2, 4'h2);
    run(4'he, POU, 5'h02, 1'b1, 1'b1, 3'h0, 4'he);
    run(4'h9, POU, 5'h04, 1'b0, 1'b0, 3'h4, 4'h9);
    run(4'h9, POU, 5'h0b, 1'b0, 1'b1, 3'h4, 4'h9);
    host.token(POU, 2'h1);
    host.abort();
    host.token(PIN, 2'h3);
    repeat (4) @(posedge sys_clk);
    check({29'h0, seen_e}, 32'h4, "abort and far endpoint");
    $display("test status and invalid done");
    apb(1'b1, 12'h000, 32'h2);
    host.token(PSU, 2'h0);
    host.data(5'h0a, 1'b0, 1'b1);
    repeat (3) @(posedge sys_clk);
    check({31'h0, ep0_locked}, 32'h1, "lock");
    apb(1'b1, 12'h004, 32'h7);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h5, "count kept");
    @(posedge sys_clk);
    check({31'h0, ep0_locked}, 32'h0, "unlock");
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h3, "write after unlock");
    host.token(PIN, 2'h0);
    repeat (3) @(posedge sys_clk);
    check({31'h0, ep0_locked}, 32'h0, "stall keeps unlocked");
    $display("test lock done");
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      irqs = 3'h0;
      @(posedge sys_clk);
      buf_corrupt <= 3'h1 << i;
      @(posedge sys_clk);
      buf_corrupt <= 3'h0;
      repeat (3) @(posedge sys_clk);
      check({29'h0, irqs}, 32'h1 << i, "corruption interrupt");
    end
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(rd, 32'h0, "reset value");
    end
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped");
    $display("test reset done");
    summarize();
  end
endmodule : usbm_ep_engine_bench
`default_nettype wire
